// >>> ips_top.sv
// priority arbitration, status reporting and register port of the
// interrupt controller; assumes cpu signals and source events come from
// logic on CLK_SYS and the register master never waits
`timescale 1ns/1ns
`include "ips_params.svh"

// Overview of operation
// [RQ1] each source priority field is three bits, 111 is level 7 down to 001 level 1.
// [RQ2] a source whose priority field is zero never raises a cpu request.
// [RQ3] after reset both source priority fields hold level 4.
// [RQ4] capture 9 priority sits in bits 6-4, compare 9 in bits 2-0, the rest read zero.
// [RQ5] bit 15 of the status register is set while a request is held off unacknowledged.
// [RQ6] with vector hold set the vector field shows the best pending vector, else the last acked.
// [RQ7] bits 11-8 of the status register give the new cpu level, 1111 being 15.
// [RQ8] bits 6-0 give the vector offset, the vector number being that value plus eight.
// [RQ9] software sets nesting disable, bit 15 of control one, before configuring sources.
// [RQ10] software clears a source flag before setting its enable bit.
// [RQ11] a flag still set after return is taken again at once, so the routine clears it.
// [RQ12] return from interrupt restores the previous cpu level and ends every routine; here each return pops only one stacked level.
// [RQ13] a trap routine clears its trap flag in control one or the trap re-enters.
// [RQ14] or-ing e0h into the status low byte lifts the cpu to 7 and blocks all user sources.
// [RQ15] trap sources at levels 8 to 15 are never masked by the cpu level.
// [RQ16] a timed disable blocks user levels 1 to 6 for a set time, level 7 still passes.
// [RQ17] the highest eligible level is offered, ties broken by the lowest vector.
module ips_top (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  // source events
  input  wire logic        CAP9_EVT,
  input  wire logic        CMP9_EVT,
  input  wire logic        TRAP_EVT,
  // cpu side
  input  wire logic [3:0]  CPU_LEVEL,
  input  wire logic        CPU_ACK,
  input  wire logic        CPU_RETURN,
  input  wire logic        TIMED_DISABLE_INSTR_LOAD,
  input  wire logic [13:0] TIMED_DISABLE_INSTR_CYCLES,
  output logic             CPU_IRQ,
  output logic      [6:0]  CPU_IRQ_VEC,
  output logic      [3:0]  CPU_IRQ_LEVEL,
  // interrupt line
  output logic             INT_OUT
);

  // ==========================================
  // reset release
  logic rst_meta_r;
  logic rstn_sync_r;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r  <= 1'b0;
      rstn_sync_r <= 1'b0;
    end else begin
      rst_meta_r  <= 1'b1;
      rstn_sync_r <= rst_meta_r;
    end
  end

  // ==========================================
  // helpers
  function automatic ips_pkg::ips_lvl_t usr_lvl(ips_pkg::ips_prio_t p);
    // [RQ1] code maps to level
    usr_lvl = {1'b0, p};
  endfunction

  function automatic logic usr_raw(logic f, logic e, ips_pkg::ips_prio_t p);
    // [RQ2] zero priority never requests
    usr_raw = f && e && (p != `IPS_PRIO_OFF);
  endfunction

  // ==========================================
  // state
  ips_pkg::ips_prio_t cap_prio_r, cap_prio_nxt;
  ips_pkg::ips_prio_t cmp_prio_r, cmp_prio_nxt;
  logic               hold_r, hold_nxt;
  logic               nest_r, nest_nxt;
  logic               trapf_r, trapf_nxt;
  logic [1:0]         flag_r, flag_nxt;
  logic [1:0]         en_r, en_nxt;
  ips_pkg::ips_word_t rdata_r, rdata_nxt;
  ips_pkg::ips_lvl_t  ilr_r, ilr_nxt;
  ips_pkg::ips_vec_t  ackvec_r, ackvec_nxt;
  ips_pkg::ips_lvl_t  stk_r [0:3];
  ips_pkg::ips_lvl_t  stk_nxt [0:3];
  logic [2:0]         sp_r, sp_nxt;
  logic [13:0]        timed_disable_instr_r, timed_disable_instr_nxt;
  logic               irq_r, irq_nxt;
  ips_pkg::ips_vec_t  ivec_r, ivec_nxt;
  ips_pkg::ips_lvl_t  ilvl_r, ilvl_nxt;
  ips_pkg::ips_svc_t  svc;

  // ==========================================
  // arbitration
  logic              raw_cap, raw_cmp, raw_any;
  logic              el_cap, el_cmp, el_trap, el_any;
  logic              usr_ok;
  ips_pkg::ips_lvl_t l_cap, l_cmp;
  ips_pkg::ips_vec_t best_vec, elig_vec;
  ips_pkg::ips_lvl_t elig_lvl;
  ips_pkg::ips_vec_t vec_field;

  assign svc = (sp_r != 3'h0) ? ips_pkg::IPS_BUSY : ips_pkg::IPS_IDLE;

  always_comb begin
    l_cap   = usr_lvl(cap_prio_r);
    l_cmp   = usr_lvl(cmp_prio_r);
    raw_cap = usr_raw(flag_r[`IPS_SRC_CAP9], en_r[`IPS_SRC_CAP9], cap_prio_r);
    raw_cmp = usr_raw(flag_r[`IPS_SRC_CMP9], en_r[`IPS_SRC_CMP9], cmp_prio_r);
    raw_any = raw_cap || raw_cmp || trapf_r;
    // no nesting of user sources while one is in service
    usr_ok  = !(nest_r && (svc == ips_pkg::IPS_BUSY));
    // [RQ14] cpu level masks user sources
    // [RQ16] timed disable spares level 7
    el_cap  = raw_cap && usr_ok && (l_cap > CPU_LEVEL) &&
              !((timed_disable_instr_r != `IPS_TIMED_DISABLE_INSTR_ZERO) && (l_cap < `IPS_LVL_USR_TOP));
    el_cmp  = raw_cmp && usr_ok && (l_cmp > CPU_LEVEL) &&
              !((timed_disable_instr_r != `IPS_TIMED_DISABLE_INSTR_ZERO) && (l_cmp < `IPS_LVL_USR_TOP));
    // [RQ15] traps ignore user masking
    el_trap = trapf_r;
    el_any  = el_cap || el_cmp || el_trap;
    // [RQ17] highest level, lowest vector on a tie
    if (el_trap) begin
      elig_vec = `IPS_VEC_TRAP;
      elig_lvl = `IPS_LVL_TRAP;
    end else if (el_cap && (!el_cmp || l_cap >= l_cmp)) begin
      elig_vec = `IPS_VEC_CAP9;
      elig_lvl = l_cap;
    end else if (el_cmp) begin
      elig_vec = `IPS_VEC_CMP9;
      elig_lvl = l_cmp;
    end else begin
      elig_vec = `IPS_VEC_NONE;
      elig_lvl = `IPS_LVL_NONE;
    end
    if (trapf_r) begin
      best_vec = `IPS_VEC_TRAP;
    end else if (raw_cap && (!raw_cmp || l_cap >= l_cmp)) begin
      best_vec = `IPS_VEC_CAP9;
    end else if (raw_cmp) begin
      best_vec = `IPS_VEC_CMP9;
    end else begin
      best_vec = `IPS_VEC_NONE;
    end
    // [RQ6] hold picks pending or last acked
    vec_field = hold_r ? best_vec : ackvec_r;
  end

  // ==========================================
  // next state
  logic ack_ok;
  logic wr_prio, wr_ctl1, wr_flag, wr_en, wr_stat;

  always_comb begin
    ack_ok  = CPU_ACK && irq_r;
    wr_prio = REG_WR && (REG_ADDR == `IPS_ADDR_PRIO);
    wr_stat = REG_WR && (REG_ADDR == `IPS_ADDR_STAT);
    wr_ctl1 = REG_WR && (REG_ADDR == `IPS_ADDR_CTL1);
    wr_flag = REG_WR && (REG_ADDR == `IPS_ADDR_FLAG);
    wr_en   = REG_WR && (REG_ADDR == `IPS_ADDR_EN);
    cap_prio_nxt = cap_prio_r;
    cmp_prio_nxt = cmp_prio_r;
    hold_nxt     = hold_r;
    nest_nxt     = nest_r;
    en_nxt       = en_r;
    ilr_nxt      = ilr_r;
    ackvec_nxt   = ackvec_r;
    sp_nxt       = sp_r;
    for (int i = 0; i < 4; i++) begin
      stk_nxt[i] = stk_r[i];
    end
    // [RQ4] field placement
    if (wr_prio) begin
      cap_prio_nxt = REG_WDATA[`IPS_CAP9_LSB +: 3];
      cmp_prio_nxt = REG_WDATA[`IPS_CMP9_LSB +: 3];
    end
    if (wr_stat) begin
      hold_nxt = REG_WDATA[`IPS_HOLD_BIT];
    end
    // [RQ9] nesting disable kept here
    if (wr_ctl1) begin
      nest_nxt = REG_WDATA[`IPS_NEST_BIT];
    end
    if (wr_en) begin
      en_nxt = REG_WDATA[1:0];
    end
    // [RQ13] trap flag cleared by write one, event wins
    trapf_nxt = TRAP_EVT ||
                (trapf_r && !(wr_ctl1 && REG_WDATA[`IPS_TRAPF_BIT]));
    // [RQ11] flag stays until cleared, event wins
    flag_nxt = {CMP9_EVT, CAP9_EVT} |
               (flag_r & ~(wr_flag ? REG_WDATA[1:0] : 2'h0));
    // [RQ12] ack pushes old level, return pops it
    if (ack_ok) begin
      ackvec_nxt = ivec_r;
      ilr_nxt    = ilvl_r;
      if (sp_r != `IPS_STK_DEPTH) begin
        stk_nxt[sp_r[1:0]] = ilr_r;
        sp_nxt = sp_r + 3'h1;
      end
    end else if (CPU_RETURN && (sp_r != 3'h0)) begin
      sp_nxt  = sp_r - 3'h1;
      ilr_nxt = stk_r[sp_nxt[1:0]];
    end
    // [RQ16] timed disable count
    if (TIMED_DISABLE_INSTR_LOAD) begin
      timed_disable_instr_nxt = TIMED_DISABLE_INSTR_CYCLES;
    end else if (timed_disable_instr_r != `IPS_TIMED_DISABLE_INSTR_ZERO) begin
      timed_disable_instr_nxt = timed_disable_instr_r - `IPS_TIMED_DISABLE_INSTR_ONE;
    end else begin
      timed_disable_instr_nxt = timed_disable_instr_r;
    end
    // request drops in the cycle after an ack so it is not taken twice
    irq_nxt  = el_any && !ack_ok;
    ivec_nxt = elig_vec;
    ilvl_nxt = elig_lvl;
    // read path, unmapped reads return zero
    rdata_nxt = 16'h0000;
    if (REG_RD) begin
      if (REG_ADDR == `IPS_ADDR_PRIO) begin
        rdata_nxt[`IPS_CAP9_LSB +: 3] = cap_prio_r;
        rdata_nxt[`IPS_CMP9_LSB +: 3] = cmp_prio_r;
      end else if (REG_ADDR == `IPS_ADDR_STAT) begin
        // [RQ5] held off and not acked
        rdata_nxt[`IPS_REQ_BIT]    = raw_any && !irq_r;
        rdata_nxt[`IPS_HOLD_BIT]   = hold_r;
        // [RQ7] new cpu level
        rdata_nxt[`IPS_ILR_LSB +: 4] = ilr_r;
        // [RQ8] vector offset
        rdata_nxt[6:0] = vec_field;
      end else if (REG_ADDR == `IPS_ADDR_CTL1) begin
        rdata_nxt[`IPS_NEST_BIT]  = nest_r;
        rdata_nxt[`IPS_TRAPF_BIT] = trapf_r;
      end else if (REG_ADDR == `IPS_ADDR_FLAG) begin
        rdata_nxt[1:0] = flag_r;
      end else if (REG_ADDR == `IPS_ADDR_EN) begin
        rdata_nxt[1:0] = en_r;
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge CLK_SYS or negedge rstn_sync_r) begin
    if (!rstn_sync_r) begin
      // [RQ3] level 4 at reset
      cap_prio_r <= `IPS_PRIO_RST;
      cmp_prio_r <= `IPS_PRIO_RST;
      hold_r     <= 1'b0;
      nest_r     <= 1'b0;
      trapf_r    <= 1'b0;
      flag_r     <= 2'h0;
      en_r       <= 2'h0;
      rdata_r    <= 16'h0000;
      ilr_r      <= `IPS_LVL_NONE;
      ackvec_r   <= `IPS_VEC_NONE;
      sp_r       <= 3'h0;
      timed_disable_instr_r     <= `IPS_TIMED_DISABLE_INSTR_ZERO;
      irq_r      <= 1'b0;
      ivec_r     <= `IPS_VEC_NONE;
      ilvl_r     <= `IPS_LVL_NONE;
      for (int i = 0; i < 4; i++) begin
        stk_r[i] <= `IPS_LVL_NONE;
      end
    end else begin
      cap_prio_r <= cap_prio_nxt;
      cmp_prio_r <= cmp_prio_nxt;
      hold_r     <= hold_nxt;
      nest_r     <= nest_nxt;
      trapf_r    <= trapf_nxt;
      flag_r     <= flag_nxt;
      en_r       <= en_nxt;
      rdata_r    <= rdata_nxt;
      ilr_r      <= ilr_nxt;
      ackvec_r   <= ackvec_nxt;
      sp_r       <= sp_nxt;
      timed_disable_instr_r     <= timed_disable_instr_nxt;
      irq_r      <= irq_nxt;
      ivec_r     <= ivec_nxt;
      ilvl_r     <= ilvl_nxt;
      for (int i = 0; i < 4; i++) begin
        stk_r[i] <= stk_nxt[i];
      end
    end
  end

  // ==========================================
  // outputs
  assign REG_RDATA     = rdata_r;
  assign CPU_IRQ       = irq_r;
  assign CPU_IRQ_VEC   = ivec_r;
  assign CPU_IRQ_LEVEL = ilvl_r;
  // interrupt line: any flagged source whose enable (mask) bit is set
  assign INT_OUT       = |(flag_r & en_r);

endmodule // ips_top

// >>> ips_params.svh
// named constants for the interrupt priority and status block
// assumes inclusion by bare name from the top module, the checker and the bench
`ifndef IPS_PARAMS_SVH
`define IPS_PARAMS_SVH
// ==========================================
// register addresses (word index on the port)
`define IPS_ADDR_PRIO   4'h0
`define IPS_ADDR_STAT   4'h1
`define IPS_ADDR_CTL1   4'h2
`define IPS_ADDR_FLAG   4'h3
`define IPS_ADDR_EN     4'h4
// ==========================================
// field positions
`define IPS_CAP9_LSB    4
`define IPS_CMP9_LSB    0
`define IPS_REQ_BIT     15
`define IPS_HOLD_BIT    13
`define IPS_ILR_LSB     8
`define IPS_NEST_BIT    15
`define IPS_TRAPF_BIT   0
`define IPS_SRC_CAP9    0
`define IPS_SRC_CMP9    1
// ==========================================
// reset values and levels
`define IPS_PRIO_RST    3'h4
`define IPS_PRIO_OFF    3'h0
`define IPS_LVL_TRAP    4'h8
`define IPS_LVL_USR_TOP 4'h7
`define IPS_LVL_NONE    4'h0
// vector offsets, actual vector is offset plus eight
`define IPS_VEC_TRAP    7'h02
`define IPS_VEC_CAP9    7'h60
`define IPS_VEC_CMP9    7'h61
`define IPS_VEC_NONE    7'h00
// level stack for nested service
`define IPS_STK_DEPTH   3'h4
`define IPS_TIMED_DISABLE_INSTR_ZERO   14'h0000
`define IPS_TIMED_DISABLE_INSTR_ONE    14'h0001
`endif

// >>> ips_pkg.sv
// types shared by the interrupt priority and status block
// assumes the constants header is on the include path
package ips_pkg;
  typedef logic [3:0]  ips_lvl_t;
  typedef logic [6:0]  ips_vec_t;
  typedef logic [2:0]  ips_prio_t;
  typedef logic [15:0] ips_word_t;
  typedef enum logic {IPS_IDLE, IPS_BUSY} ips_svc_t;
endpackage

// >>> ips_top_monitor.sv
// checker on the ports of the interrupt priority and status block
// assumes CLK_SYS is the only clock and RSTN low holds all outputs at 0
`timescale 1ns/1ns
`include "ips_params.svh"
// ==========================================
// port checker
module ips_top_monitor (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  // register port
  input wire logic [3:0]  REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  // cpu side
  input wire logic [3:0]  CPU_LEVEL,
  input wire logic        CPU_ACK,
  input wire logic        TIMED_DISABLE_INSTR_LOAD,
  input wire logic [13:0] TIMED_DISABLE_INSTR_CYCLES,
  input wire logic        CPU_IRQ,
  input wire logic [6:0]  CPU_IRQ_VEC,
  input wire logic [3:0]  CPU_IRQ_LEVEL
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_irq_above_cpu: assert property (
    CPU_IRQ && CPU_IRQ_LEVEL < `IPS_LVL_TRAP
    |-> CPU_IRQ_LEVEL > $past(CPU_LEVEL)) else $error("irq not above cpu");
  a_ack_drops_irq: assert property (
    CPU_IRQ && CPU_ACK |=> !CPU_IRQ) else $error("irq kept after ack");
  a_rdata_idle: assert property (
    !REG_RD |=> REG_RDATA == 16'h0000) else $error("read data not idle");
  a_prio_unused_zero: assert property (
    REG_RD && REG_ADDR == `IPS_ADDR_PRIO
    |=> (REG_RDATA & 16'hff88) == 16'h0000) else $error("prio spare bits");
  a_stat_unused_zero: assert property (
    REG_RD && REG_ADDR == `IPS_ADDR_STAT
    |=> (REG_RDATA & 16'h5080) == 16'h0000) else $error("stat spare bits");
  a_trap_level: assert property (
    CPU_IRQ && CPU_IRQ_VEC == `IPS_VEC_TRAP
    |-> CPU_IRQ_LEVEL == `IPS_LVL_TRAP) else $error("trap level wrong");
  a_user_nonzero: assert property (
    CPU_IRQ |-> CPU_IRQ_LEVEL != `IPS_LVL_NONE) else $error("level 0 irq");
  // a load longer than the window must hold levels 1 to 6 off
  a_timed_disable_instr_block: assert property (
    TIMED_DISABLE_INSTR_LOAD && TIMED_DISABLE_INSTR_CYCLES > 14'h0008 |-> ##2
    (!CPU_IRQ || CPU_IRQ_LEVEL >= `IPS_LVL_USR_TOP)[*4])
    else $error("disable window broken");
endmodule // ips_top_monitor

bind ips_top ips_top_monitor i_ips_top_monitor (.CLK_SYS, .RSTN,
  .REG_ADDR, .REG_RD, .REG_RDATA, .CPU_LEVEL, .CPU_ACK, .TIMED_DISABLE_INSTR_LOAD,
  .TIMED_DISABLE_INSTR_CYCLES, .CPU_IRQ, .CPU_IRQ_VEC, .CPU_IRQ_LEVEL);

// >>> ips_cpu_model.sv
// cpu core model: takes offered requests and runs at the taken level
// assumes the bench stalls it to watch requests that stay offered
`timescale 1ns/1ns
// ==========================================
// cpu model
module ips_cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // block side
  input  wire logic       irq,
  input  wire logic [3:0] irq_level,
  output logic            ack,
  output logic [3:0]      level,
  // bench control
  input  wire logic       stall,
  input  wire logic       ret,
  input  wire logic [3:0] base
);
  logic       ack_r, ack_nxt, busy_r, busy_nxt;
  logic [3:0] lvl_r, lvl_nxt;
  always_comb begin
    ack_nxt  = irq & ~stall & ~ack_r;
    busy_nxt = (busy_r | ack_nxt) & ~ret;
    lvl_nxt  = ack_nxt ? irq_level : (busy_r & ~ret) ? lvl_r : base;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r  <= 1'b0;
      busy_r <= 1'b0;
      lvl_r  <= 4'h0;
    end else begin
      ack_r  <= ack_nxt;
      busy_r <= busy_nxt;
      lvl_r  <= lvl_nxt;
    end
  end
  assign ack   = ack_r;
  assign level = lvl_r;
endmodule // ips_cpu_model

// >>> interrupt_priority_status_tb_top.sv
// self-checking bench for the interrupt priority and status block
// assumes ips_top, ips_cpu_model and the bound checker are compiled
`timescale 1ns/1ns
`include "ips_params.svh"
// ==========================================
// bench
module interrupt_priority_status_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        cap = 1'b0, cmp = 1'b0, trap = 1'b0, ret = 1'b0;
  logic        timed_disable_instr = 1'b0, stall = 1'b1, ack, irq, int_out;
  logic [3:0]  addr = 4'h0, base = 4'h0, cpu_lvl, lvl;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic [13:0] dcyc = 14'h0000;
  logic [6:0]  vec;
  int          error_cnt = 0, check_count = 0;
  always #4 clk = ~clk;
  ips_top i_ips_top (.CLK_SYS(clk), .RSTN(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .CAP9_EVT(cap), .CMP9_EVT(cmp), .TRAP_EVT(trap), .CPU_LEVEL(cpu_lvl),
    .CPU_ACK(ack), .CPU_RETURN(ret), .TIMED_DISABLE_INSTR_LOAD(timed_disable_instr), .TIMED_DISABLE_INSTR_CYCLES(dcyc),
    .CPU_IRQ(irq), .CPU_IRQ_VEC(vec), .CPU_IRQ_LEVEL(lvl),
    .INT_OUT(int_out));
  ips_cpu_model i_ips_cpu_model (.clk(clk), .rst_n(rst_n), .irq(irq),
    .irq_level(lvl), .ack(ack), .level(cpu_lvl), .stall(stall),
    .ret(ret), .base(base));
  // ==========================================
  // shared tasks
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse(logic [2:0] m);
    @(posedge clk);
    {trap, cmp, cap} <= m;
    @(posedge clk);
    {trap, cmp, cap} <= 3'b000;
  endtask
  // ==========================================
  // scenarios
  // request, level and vector packed into one compare word
  function automatic logic [15:0] iw(logic i, logic [3:0] l, logic [6:0] w);
    iw = {4'h0, i, l, w};
  endfunction
  task automatic t_regs;
    rreg(`IPS_ADDR_PRIO);
    chk("prio reset", v, 16'h0044);
    wreg(`IPS_ADDR_PRIO, 16'hffff);
    rreg(`IPS_ADDR_PRIO);
    chk("prio fields", v, 16'h0077);
    wreg(`IPS_ADDR_CTL1, 16'h8000);
    rreg(`IPS_ADDR_CTL1);
    chk("nest bit", v, 16'h8000);
    wreg(`IPS_ADDR_CTL1, 16'h0000);
    rreg(4'hf);
    chk("unmapped", v, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_zero;
    wreg(`IPS_ADDR_PRIO, 16'h0000);
    wreg(`IPS_ADDR_FLAG, 16'h0003);
    wreg(`IPS_ADDR_EN, 16'h0003);
    pulse(3'b011);
    cyc(3);
    chk("irq prio zero", {15'h0000, irq}, 16'h0000);
    rreg(`IPS_ADDR_STAT);
    chk("no raw request", v, 16'h0000);
    chk("int line", {15'h0000, int_out}, 16'h0001);
    wreg(`IPS_ADDR_EN, 16'h0000);
    cyc(2);
    chk("int masked", {15'h0000, int_out}, 16'h0000);
    wreg(`IPS_ADDR_EN, 16'h0003);
    wreg(`IPS_ADDR_FLAG, 16'h0003);
    cyc(2);
    chk("int cleared", {15'h0000, int_out}, 16'h0000);
    $display("test zero done");
  endtask
  task automatic t_tie;
    wreg(`IPS_ADDR_PRIO, 16'h0077);
    pulse(3'b011);
    cyc(2);
    chk("tie", iw(irq, lvl, vec), iw(1'b1, 4'h7, `IPS_VEC_CAP9));
    wreg(`IPS_ADDR_PRIO, 16'h0017);
    cyc(2);
    chk("level", iw(irq, lvl, vec), iw(1'b1, 4'h7, `IPS_VEC_CMP9));
    @(posedge clk) base <= 4'h7;
    wreg(`IPS_ADDR_STAT, 16'h2000);
    rreg(`IPS_ADDR_STAT);
    chk("held off", v, 16'ha061);
    chk("hold vector", {9'h000, v[6:0]}, {9'h000, `IPS_VEC_CMP9});
    chk("user masked", {15'h0000, irq}, 16'h0000);
    @(posedge clk) base <= 4'h0;
    @(posedge clk) stall <= 1'b0;
    cyc(6);
    @(posedge clk) stall <= 1'b1;
    wreg(`IPS_ADDR_STAT, 16'h0000);
    rreg(`IPS_ADDR_STAT);
    chk("acked", v, 16'h8761);
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
    cyc(3);
    chk("retaken", {8'h00, irq, vec}, {8'h00, 1'b1, `IPS_VEC_CMP9});
    rreg(`IPS_ADDR_STAT);
    chk("popped", v, 16'h0061);
    wreg(`IPS_ADDR_FLAG, 16'h0003);
    cyc(2);
    chk("flag cleared", {15'h0000, irq}, 16'h0000);
    $display("test tie done");
  endtask
  task automatic t_trap;
    @(posedge clk) base <= 4'hf;
    pulse(3'b100);
    cyc(2);
    chk("trap", iw(irq, lvl, vec), iw(1'b1, 4'h8, `IPS_VEC_TRAP));
    wreg(`IPS_ADDR_CTL1, 16'h0001);
    cyc(2);
    chk("trap cleared", {15'h0000, irq}, 16'h0000);
    @(posedge clk) base <= 4'h0;
    $display("test trap done");
  endtask
  task automatic t_timed_disable_instr;
    wreg(`IPS_ADDR_PRIO, 16'h0076);
    @(posedge clk) dcyc <= 14'h0028;
    timed_disable_instr <= 1'b1;
    @(posedge clk) timed_disable_instr <= 1'b0;
    pulse(3'b010);
    cyc(2);
    chk("timed_disable_instr blocks", {15'h0000, irq}, 16'h0000);
    pulse(3'b001);
    cyc(2);
    chk("top passes", {8'h00, irq, vec}, {8'h00, 1'b1, `IPS_VEC_CAP9});
    wreg(`IPS_ADDR_FLAG, 16'h0001);
    cyc(40);
    chk("expired", iw(irq, lvl, vec), iw(1'b1, 4'h6, `IPS_VEC_CMP9));
    // take the level 6 request, then hold nesting off
    @(posedge clk) stall <= 1'b0;
    cyc(4);
    @(posedge clk) stall <= 1'b1;
    wreg(`IPS_ADDR_CTL1, 16'h8000);
    pulse(3'b001);
    cyc(2);
    chk("nest blocks", {15'h0000, irq}, 16'h0000);
    wreg(`IPS_ADDR_CTL1, 16'h0000);
    cyc(2);
    chk("nest off", iw(irq, lvl, vec), iw(1'b1, 4'h7, `IPS_VEC_CAP9));
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
    wreg(`IPS_ADDR_FLAG, 16'h0003);
    $display("test timed_disable_instr done");
  endtask
  // ==========================================
  // run and verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
    t_regs;
    t_zero;
    t_tie;
    t_trap;
    t_timed_disable_instr;
    close_out;
  end
  // the tests need well under 400 cycles
  initial begin
    #40000;
    error_cnt++;
    close_out;
  end
endmodule // interrupt_priority_status_tb_top
